// *** pfpm_in_router.sv ***
// pfpm_in_router: routes gated pin levels to the remappable peripheral inputs
`timescale 1ns/1ps
`default_nettype none
module pfpm_in_router (
    // select fields, one nibble per remappable input
    input wire logic [pfpm_pkg::NRIN*pfpm_pkg::SEL_W-1:0] inSel,
    // gated pin levels
    input wire logic [pfpm_pkg::NPINS-1:0] digIn,
    // routed values
    output logic [pfpm_pkg::NRIN-1:0] routed
);
    import pfpm_pkg::*;

    // each input reads any pin; nothing stops several sharing one pin
    for (genvar k = 0; k < NRIN; k++) begin : g_route
        logic [2:0] pinIdx;
        assign pinIdx = inSel[k*SEL_W + RIN_PIN_LSB +: 3];
        assign routed[k] = inSel[k*SEL_W + RIN_EN_BIT] & digIn[pinIdx];
    end
endmodule : pfpm_in_router
`default_nettype wire

// *** pfpm_mux_top.sv ***
// pfpm_mux_top: pin function priority mux with its Avalon-MM register file
//
// How it works
// - every reset brings all shared analog pins up in analog mode.
// - analog-selected pin reads zero through port and latch reads; input buffer off.
// - writing zero to a pin's analog select bit frees it for digital use.
// - general output driver still works under direction control with analog selected.
// - higher priority pin function overrides all lower ones while it is enabled.
// - at most one output function drives any pin at a time.
// - one remappable output may drive several pins with the same signal.
// - dedicated output beats any remappable output mapped to the pin.
// - remappable inputs may map onto pins owned by dedicated digital functions.
// - dedicated analog function disables all digital inputs; one output may remain.
// - any number of remappable inputs may sample the same pin at once.
// - each pin has independent weak pull-up and pull-down enables.
`timescale 1ns/1ps
`default_nettype none
module pfpm_mux_top (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [pfpm_pkg::ADDR_W-1:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    // pins
    input wire logic [pfpm_pkg::NPINS-1:0] pinIn,
    output logic [pfpm_pkg::NPINS-1:0] pinOut,
    output logic [pfpm_pkg::NPINS-1:0] pinOe,
    output logic [pfpm_pkg::NPINS-1:0] pullUpEn,
    output logic [pfpm_pkg::NPINS-1:0] pullDownEn,
    output logic [pfpm_pkg::NPINS-1:0] inBufEn,
    // dedicated peripheral functions
    input wire logic [pfpm_pkg::NPINS-1:0] dedOutEn,
    input wire logic [pfpm_pkg::NPINS-1:0] dedOutVal,
    input wire logic [pfpm_pkg::NPINS-1:0] dedAnaEn,
    // remappable peripheral functions
    input wire logic [pfpm_pkg::NROUT-1:0] remapOutVal,
    output logic [pfpm_pkg::NRIN-1:0] remapInVal
);
    import pfpm_pkg::*;

    // ********************************
    // register state
    // ********************************
    logic [7:0] anaSel_r;
    logic [7:0] dir_r;
    logic [7:0] lat_r;
    logic [7:0] pullUp_r;
    logic [7:0] pullDn_r;
    logic [31:0] routSel_r;
    logic [15:0] rinSel_r;
    logic waitReq_r;
    logic [31:0] rdData_r;

    logic wrFire;
    logic [31:0] rdData_nxt;
    logic [NPINS-1:0] drvOe;
    logic [NPINS-1:0] drvVal;
    logic [NPINS-1:0] digIn;
    logic [NPINS-1:0] bufEn;
    logic [NRIN-1:0] routed;
    logic [7:0] analogOn;

    assign analogOn = anaSel_r | dedAnaEn;

    // ********************************
    // bus handshake
    // ********************************

    // waitrequest drops for one cycle after a request is seen; a write lands
    // and read data is valid on the edge the master sees it low
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            waitReq_r <= 1'b1;
        end else if (ce) begin
            if ((avsRead || avsWrite) && waitReq_r) begin
                waitReq_r <= 1'b0;
            end else begin
                waitReq_r <= 1'b1;
            end
        end
    end

    assign wrFire = ce && avsWrite && !waitReq_r;
    assign avsWaitrequest = waitReq_r;
    assign avsReaddata = rdData_r;

    // read mux; unmapped offsets read as zero
    always_comb begin
        rdData_nxt = 32'h0000_0000;
        case (avsAddress & 6'h3C)
            OFF_ANALOG: rdData_nxt = {24'h00_0000, anaSel_r};
            OFF_DIR: rdData_nxt = {24'h00_0000, dir_r};
            OFF_LATCH: rdData_nxt = {24'h00_0000, lat_r & ~analogOn};
            OFF_PORT: rdData_nxt = {24'h00_0000, digIn};
            OFF_PULLUP: rdData_nxt = {24'h00_0000, pullUp_r};
            OFF_PULLDN: rdData_nxt = {24'h00_0000, pullDn_r};
            OFF_ROUT: rdData_nxt = routSel_r;
            OFF_RIN: rdData_nxt = {16'h0000, rinSel_r};
            default: rdData_nxt = 32'h0000_0000;
        endcase
    end

    // read data captured as waitrequest falls, held until the next read
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdData_r <= 32'h0000_0000;
        end else if (ce && avsRead && waitReq_r) begin
            rdData_r <= rdData_nxt;
        end
    end

    // ********************************
    // configuration registers
    // ********************************

    // analog select; every reset returns shared pins to analog
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            anaSel_r <= RST_ANALOG;
        end else if (wrFire && (avsAddress & 6'h3C) == OFF_ANALOG) begin
            anaSel_r <= 8'(be_merge({24'h00_0000, anaSel_r}, avsWritedata, avsByteenable));
        end
    end

    // direction, one means input
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dir_r <= RST_DIR;
        end else if (wrFire && (avsAddress & 6'h3C) == OFF_DIR) begin
            dir_r <= 8'(be_merge({24'h00_0000, dir_r}, avsWritedata, avsByteenable));
        end
    end

    // output latch; the port offset writes the latch too, as is usual for gpio
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lat_r <= RST_LATCH;
        end else if (wrFire && ((avsAddress & 6'h3C) == OFF_LATCH ||
                                (avsAddress & 6'h3C) == OFF_PORT)) begin
            lat_r <= 8'(be_merge({24'h00_0000, lat_r}, avsWritedata, avsByteenable));
        end
    end

    // weak pull enables, kept independent so both may be on at once
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pullUp_r <= RST_PULL;
            pullDn_r <= RST_PULL;
        end else if (wrFire) begin
            if ((avsAddress & 6'h3C) == OFF_PULLUP) begin
                pullUp_r <= 8'(be_merge({24'h00_0000, pullUp_r}, avsWritedata,
                                        avsByteenable));
            end
            if ((avsAddress & 6'h3C) == OFF_PULLDN) begin
                pullDn_r <= 8'(be_merge({24'h00_0000, pullDn_r}, avsWritedata,
                                        avsByteenable));
            end
        end
    end

    // remappable selects: one nibble per pin out, one nibble per input in
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            routSel_r <= RST_ROUT;
            rinSel_r <= RST_RIN;
        end else if (wrFire) begin
            if ((avsAddress & 6'h3C) == OFF_ROUT) begin
                routSel_r <= be_merge(routSel_r, avsWritedata, avsByteenable);
            end
            if ((avsAddress & 6'h3C) == OFF_RIN) begin
                rinSel_r <= 16'(be_merge({16'h0000, rinSel_r}, avsWritedata, avsByteenable));
            end
        end
    end

    // ********************************
    // pin arbitration
    // ********************************
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        pfpm_pin_cell u_cell (
            .anaSel(anaSel_r[i]),
            .dirIn(dir_r[i]),
            .latVal(lat_r[i]),
            .remapCode(routSel_r[i*SEL_W +: SEL_W]),
            .dedOutEn(dedOutEn[i]),
            .dedOutVal(dedOutVal[i]),
            .dedAnaEn(dedAnaEn[i]),
            .remapOutVal(remapOutVal),
            .pinIn(pinIn[i]),
            .drvOe(drvOe[i]),
            .drvVal(drvVal[i]),
            .digIn(digIn[i]),
            .bufEn(bufEn[i])
        );
    end

    pfpm_in_router u_router (
        .inSel(rinSel_r),
        .digIn(digIn),
        .routed(routed)
    );

    // pin-facing outputs registered: costs a cycle, keeps pins glitch free
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pinOut <= '0;
            pinOe <= '0;
            inBufEn <= '0;
        end else if (ce) begin
            pinOut <= drvVal;
            pinOe <= drvOe;
            inBufEn <= bufEn;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pullUpEn <= '0;
            pullDownEn <= '0;
            remapInVal <= '0;
        end else if (ce) begin
            pullUpEn <= pullUp_r;
            pullDownEn <= pullDn_r;
            remapInVal <= routed;
        end
    end

    // ********************************
    // assertions
    // ********************************
    a_reset_analog: assert property (@(posedge clock)
        !arst_n |-> (anaSel_r == RST_ANALOG))
        else $error("analog select not at reset value");

    a_analog_buf_off: assert property (@(posedge clock) disable iff (!arst_n)
        ce |=> ((inBufEn & $past(analogOn)) == 8'h00))
        else $error("input buffer on for analog pin");

    a_port_read_zero: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && avsRead && waitReq_r && (avsAddress & 6'h3C) == OFF_PORT)
        |=> ((avsReaddata[7:0] & $past(analogOn)) == 8'h00))
        else $error("port read not zero on analog pin");

    a_release_digital: assert property (@(posedge clock) disable iff (!arst_n)
        (wrFire && (avsAddress & 6'h3C) == OFF_ANALOG && avsByteenable[0]
         && !avsWritedata[0] && !dedAnaEn[0]) ##1 (ce && !dedAnaEn[0])
        |=> inBufEn[0])
        else $error("pin not released for digital use");

    a_gpio_under_analog: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && anaSel_r[0] && !dedOutEn[0] && routSel_r[3:0] == ROUT_NONE && !dir_r[0])
        |=> (pinOe[0] && pinOut[0] == $past(lat_r[0])))
        else $error("latch driver lost under analog select");

    a_dedicated_wins: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && dedOutEn[1] && routSel_r[7:4] != ROUT_NONE)
        |=> (pinOe[1] && pinOut[1] == $past(dedOutVal[1])))
        else $error("dedicated output did not win");

    a_remap_drives: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && !dedOutEn[2] && routSel_r[11:8] == 4'h3)
        |=> (pinOe[2] && pinOut[2] == $past(remapOutVal[2])))
        else $error("remapped output did not beat latch");

    a_one_output: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && !dedOutEn[2] && routSel_r[11:8] == ROUT_NONE && dir_r[2])
        |=> !pinOe[2])
        else $error("pin driven with no owner");

    a_shared_remap: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && routSel_r[11:8] == routSel_r[15:12] && routSel_r[11:8] != ROUT_NONE
         && routSel_r[11:8] <= ROUT_MAX && !dedOutEn[2] && !dedOutEn[3])
        |=> (pinOut[2] == pinOut[3] && pinOe[2] && pinOe[3]))
        else $error("shared remap pins differ");

    a_shared_input: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && rinSel_r[3:0] == rinSel_r[7:4] && rinSel_r[RIN_EN_BIT])
        |=> (remapInVal[0] == remapInVal[1]))
        else $error("remapped inputs on one pin disagree");

    a_input_on_dedicated: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && dedOutEn[1] && !analogOn[1] && rinSel_r[3:0] == 4'h9)
        |=> (remapInVal[0] == $past(pinIn[1])))
        else $error("input lost on dedicated pin");

    a_dedicated_analog: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && dedAnaEn[1] && rinSel_r[3:0] == 4'h9) |=> !remapInVal[0])
        else $error("digital input alive under analog");

    a_pull_follow: assert property (@(posedge clock) disable iff (!arst_n)
        ce |=> (pullUpEn == $past(pullUp_r) && pullDownEn == $past(pullDn_r)))
        else $error("pull enables do not follow registers");

    a_bus_answer: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && (avsRead || avsWrite) && avsWaitrequest) |=> !avsWaitrequest)
        else $error("bus answer late");

    c_ded_override: cover property (@(posedge clock) disable iff (!arst_n)
        ce && dedOutEn[1] && routSel_r[7:4] != ROUT_NONE);
    c_analog_read: cover property (@(posedge clock) disable iff (!arst_n)
        ce && avsRead && !waitReq_r && (avsAddress & 6'h3C) == OFF_PORT && anaSel_r != 8'h00);
    c_remap_multi: cover property (@(posedge clock) disable iff (!arst_n)
        ce && routSel_r[11:8] == routSel_r[15:12] && routSel_r[11:8] != ROUT_NONE);
endmodule : pfpm_mux_top
`default_nettype wire

// *** pfpm_pin_cell.sv ***
// pfpm_pin_cell: output arbitration and input gating for one pin
`timescale 1ns/1ps
`default_nettype none
module pfpm_pin_cell (
    // configuration
    input wire logic anaSel,
    input wire logic dirIn,
    input wire logic latVal,
    input wire logic [3:0] remapCode,
    // peripheral side
    input wire logic dedOutEn,
    input wire logic dedOutVal,
    input wire logic dedAnaEn,
    input wire logic [pfpm_pkg::NROUT-1:0] remapOutVal,
    // pin side
    input wire logic pinIn,
    output logic drvOe,
    output logic drvVal,
    output logic digIn,
    output logic bufEn
);
    import pfpm_pkg::*;

    logic analogOn;
    logic remapHit;

    // analog ownership kills every digital input path but not the driver
    assign analogOn = anaSel | dedAnaEn;
    assign bufEn = ~analogOn;
    assign digIn = pinIn & ~analogOn;
    assign remapHit = (remapCode != ROUT_NONE) && (remapCode <= ROUT_MAX);

    // one driver only: dedicated, then remapped, then the general latch
    always_comb begin
        if (dedOutEn) begin
            drvOe = 1'b1;
            drvVal = dedOutVal;
        end else if (remapHit) begin
            drvOe = 1'b1;
            drvVal = remapOutVal[rout_index(remapCode)];
        end else begin
            drvOe = ~dirIn;
            drvVal = latVal;
        end
    end
endmodule : pfpm_pin_cell
`default_nettype wire

// *** pfpm_pin_model.sv ***
// pfpm_pin_model: behavioural board circuitry that resolves each pin's level
`timescale 1ns/1ps
`default_nettype none
module pfpm_pin_model (
    // clock for the floating-pin pattern
    input wire logic clock,
    // device pin side
    input wire logic [pfpm_pkg::NPINS-1:0] pinOut,
    input wire logic [pfpm_pkg::NPINS-1:0] pinOe,
    input wire logic [pfpm_pkg::NPINS-1:0] pullUpEn,
    input wire logic [pfpm_pkg::NPINS-1:0] pullDownEn,
    // external source commanded by the bench
    input wire logic [pfpm_pkg::NPINS-1:0] extEn,
    input wire logic [pfpm_pkg::NPINS-1:0] extVal,
    output logic [pfpm_pkg::NPINS-1:0] pinIn
);
    import pfpm_pkg::*;
    logic [NPINS-1:0] floatPat = 8'hA5;

    // an undriven, unpulled pin wanders so a stale level never reads as valid
    always @(posedge clock) begin
        floatPat <= ~floatPat;
    end

    // ********************************
    // wire resolution
    // ********************************
    // two drivers that disagree give contention, shown as unknown
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (pinOe[i] && extEn[i]) begin
                pinIn[i] = (pinOut[i] == extVal[i]) ? pinOut[i] : 1'bx;
            end else if (pinOe[i]) begin
                pinIn[i] = pinOut[i];
            end else if (extEn[i]) begin
                pinIn[i] = extVal[i];
            end else if (pullUpEn[i] && !pullDownEn[i]) begin
                pinIn[i] = 1'b1;
            end else if (pullDownEn[i] && !pullUpEn[i]) begin
                pinIn[i] = 1'b0;
            end else begin
                pinIn[i] = floatPat[i];
            end
        end
    end
endmodule : pfpm_pin_model
`default_nettype wire

// *** pfpm_pkg.sv ***
// pfpm_pkg: shared constants, register map and helpers for the pin function mux
package pfpm_pkg;

    // ********************************
    // sizes
    // ********************************
    localparam int NPINS = 8;
    localparam int NROUT = 4;
    localparam int NRIN = 4;
    localparam int SEL_W = 4;
    localparam int ADDR_W = 6;

    // ********************************
    // register byte offsets
    // ********************************
    localparam logic [5:0] OFF_ANALOG = 6'h00;
    localparam logic [5:0] OFF_DIR = 6'h04;
    localparam logic [5:0] OFF_LATCH = 6'h08;
    localparam logic [5:0] OFF_PORT = 6'h0C;
    localparam logic [5:0] OFF_PULLUP = 6'h10;
    localparam logic [5:0] OFF_PULLDN = 6'h14;
    localparam logic [5:0] OFF_ROUT = 6'h18;
    localparam logic [5:0] OFF_RIN = 6'h1C;

    // ********************************
    // reset values
    // ********************************
    localparam logic [7:0] RST_ANALOG = 8'hFF;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_PULL = 8'h00;
    localparam logic [31:0] RST_ROUT = 32'h0000_0000;
    localparam logic [15:0] RST_RIN = 16'h0000;

    // ********************************
    // field layout of select nibbles
    // ********************************
    localparam int RIN_EN_BIT = 3;
    localparam int RIN_PIN_LSB = 0;
    localparam logic [3:0] ROUT_NONE = 4'h0;
    localparam logic [3:0] ROUT_MAX = 4'h4;

    // byte-lane merge used by every writable register
    function automatic logic [31:0] be_merge(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = oldVal;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = newVal[b*8 +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // remappable output code 1..4 picks source 0..3
    function automatic logic [1:0] rout_index(input logic [3:0] code);
        logic [3:0] idx;
        idx = code - 4'h1;
        return idx[1:0];
    endfunction : rout_index

endpackage : pfpm_pkg

// *** tb.sv ***
// tb: register-level tests of the pin function mux against a board model
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pfpm_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b1;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] avsAddress = 6'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [3:0] avsByteenable = 4'hF;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic [NPINS-1:0] pinIn, pinOut, pinOe, pullUpEn, pullDownEn, inBufEn;
    logic [NPINS-1:0] dedOutEn = 8'h00, dedOutVal = 8'h00, dedAnaEn = 8'h00;
    logic [NPINS-1:0] extEn = 8'h00, extVal = 8'h00;
    logic [NROUT-1:0] remapOutVal = 4'h0;
    logic [NRIN-1:0] remapInVal;
    logic [31:0] rd;
    int errorCnt = 0;
    int totalChecks = 0;

    pfpm_mux_top uut (.clock(clock), .arst_n(arst_n), .ce(ce), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .inBufEn(inBufEn),
        .dedOutEn(dedOutEn), .dedOutVal(dedOutVal), .dedAnaEn(dedAnaEn),
        .remapOutVal(remapOutVal), .remapInVal(remapInVal));

    pfpm_pin_model board (.clock(clock), .pinOut(pinOut), .pinOe(pinOe),
        .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .extEn(extEn), .extVal(extVal),
        .pinIn(pinIn));

    // ********************************
    // clock, verdict and watchdog
    // ********************************
    initial begin
        forever #2 clock = ~clock;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // the tests need under two hundred cycles; this margin only catches a hang
    initial begin
        #40000;
        errorCnt++;
        end_of_test();
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // ********************************
    // avalon-mm master
    // ********************************
    // holds the request until waitrequest is seen low at an edge, then drops it
    task automatic bus_xfer(input logic isWr, input logic [5:0] addr, input logic [31:0] data,
                            output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge clock);
        avsAddress <= addr;
        avsWritedata <= data;
        avsRead <= !isWr;
        avsWrite <= isWr;
        // waitrequest and read data are taken at one edge; only the watchdog ends a hang
        do begin
            @(posedge clock);
            n++;
        end while (avsWaitrequest !== 1'b0);
        rdata = avsReaddata;
        check("wait cycles", n, 32'h2);
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask : bus_xfer

    task automatic wr(input logic [5:0] addr, input logic [31:0] data);
        logic [31:0] dummy;
        bus_xfer(1'b1, addr, data, dummy);
    endtask : wr

    task automatic rd_chk(input string name, input logic [5:0] addr, input logic [31:0] exp);
        bus_xfer(1'b0, addr, 32'h0, rd);
        check(name, rd, exp);
    endtask : rd_chk

    // pins follow config one edge later; extra edges let the pin loop settle
    task automatic settle;
        repeat (4) @(posedge clock);
    endtask : settle

    // ********************************
    // test sequence
    // ********************************
    initial begin
        arst_n <= 1'b0;
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        // reset values of the map except latch and port
        rd_chk("analog", OFF_ANALOG, 32'h0000_00FF);
        rd_chk("dir", OFF_DIR, 32'h0000_00FF);
        rd_chk("pullup", OFF_PULLUP, 32'h0);
        rd_chk("pulldown", OFF_PULLDN, 32'h0);
        rd_chk("rout", OFF_ROUT, 32'h0);
        rd_chk("rin", OFF_RIN, 32'h0);
        // analog pins hide the external level from every read
        extEn <= 8'hFF;
        extVal <= 8'hFF;
        settle();
        check("inBufEn", {24'h0, inBufEn}, 32'h0);
        rd_chk("port analog", OFF_PORT, 32'h0);
        wr(OFF_LATCH, 32'h5A);
        rd_chk("latch analog", OFF_LATCH, 32'h0);
        extEn <= 8'h00;
        // output driver still works with analog selected
        wr(OFF_DIR, 32'h00);
        settle();
        check("pinOe", {24'h0, pinOe}, 32'hFF);
        check("pinOut", {24'h0, pinOut}, 32'h5A);
        // release to digital: input path returns
        wr(OFF_ANALOG, 32'h00);
        settle();
        check("inBufEn", {24'h0, inBufEn}, 32'hFF);
        rd_chk("port digital", OFF_PORT, 32'h5A);
        rd_chk("latch digital", OFF_LATCH, 32'h5A);
        // weak pulls on undriven pins
        wr(OFF_DIR, 32'hFF);
        wr(OFF_PULLUP, 32'h0F);
        wr(OFF_PULLDN, 32'hF0);
        settle();
        check("pullUpEn", {24'h0, pullUpEn}, 32'h0F);
        check("pullDownEn", {24'h0, pullDownEn}, 32'hF0);
        rd_chk("port pulled", OFF_PORT, 32'h0F);
        // one remap source on three pins, dedicated output wins on pin 1
        wr(OFF_DIR, 32'h00);
        wr(OFF_ROUT, 32'h0000_3331);
        remapOutVal <= 4'b0100;
        dedOutEn <= 8'h02;
        settle();
        check("pinOut remap", {24'h0, pinOut}, 32'h5C);
        remapOutVal <= 4'b0001;
        settle();
        check("pinOut remap2", {24'h0, pinOut}, 32'h51);
        check("pinOe one", {24'h0, pinOe}, 32'hFF);
        // four remap inputs sample pin 1 owned by the dedicated output
        wr(OFF_RIN, 32'h0000_9999);
        dedOutVal <= 8'h02;
        settle();
        check("remapIn hi", {28'h0, remapInVal}, 32'hF);
        dedOutVal <= 8'h00;
        settle();
        check("remapIn lo", {28'h0, remapInVal}, 32'h0);
        // dedicated analog kills inputs but leaves the driver
        dedOutVal <= 8'h02;
        dedAnaEn <= 8'h02;
        settle();
        check("remapIn ana", {28'h0, remapInVal}, 32'h0);
        check("inBufEn ana", {24'h0, inBufEn}, 32'hFD);
        check("pinOut ana", {31'h0, pinOut[1]}, 32'h1);
        // unmapped space reads zero and ignores writes
        // clock enable low freezes the registered pin drive
        ce <= 1'b0;
        dedOutVal <= 8'h00;
        settle();
        check("pinOut frozen", {31'h0, pinOut[1]}, 32'h1);
        ce <= 1'b1;
        settle();
        check("pinOut thawed", {31'h0, pinOut[1]}, 32'h0);
        wr(6'h20, 32'hFFFF_FFFF);
        rd_chk("unmapped", 6'h20, 32'h0);
        // a second reset in mid-run brings every pin back to analog
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rd_chk("analog again", OFF_ANALOG, 32'h0000_00FF);
        check("inBufEn again", {24'h0, inBufEn}, 32'h0);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
